// [mrpd_link_asserts.sv]
// Pin checker for the link between both ends.
// Assumes tb wires it to the interface signals.
`timescale 1ns/1ns
module mrpd_link_asserts
(
   input logic i_core_clk,
   input logic i_srst,
   input logic ref_clk,
   input logic i_link_srst,
   input logic i_rmii_mode,
   input logic i_speed100,
   input logic i_full_duplex,
   input logic tx_clk,
   input logic rx_clk,
   input logic tx_en,
   input logic [3:0] txd,
   input logic rx_dv,
   input logic rx_er,
   input logic crs,
   input logic [3:0] rxd_o,
   input logic rxd_oe,
   input logic col_o,
   input logic col_oe,
   input logic mdc
);
   //////////////////////////////
   // Device end, reference clock domain
   property p_tx_rate;
      @(posedge ref_clk) disable iff (i_link_srst)
         !i_rmii_mode && i_speed100 && $rose(tx_clk) |=> !tx_clk;
   endproperty
   a_tx_rate: assert property (p_tx_rate) else $error("tx clk rate");
   property p_rx_phase;
      @(posedge ref_clk) disable iff (i_link_srst)
         !i_rmii_mode |-> rx_clk == tx_clk;
   endproperty
   a_rx_phase: assert property (p_rx_phase) else $error("clk phase");
   property p_rmii_quiet;
      @(posedge ref_clk) disable iff (i_link_srst) i_rmii_mode |-> !tx_clk;
   endproperty
   a_rmii_quiet: assert property (p_rmii_quiet) else $error("tx clk");
   // Both corrupt encodings carry bit 1 high in the reduced mode
   property p_err_data;
      @(posedge ref_clk) disable iff (i_link_srst) rx_er |->
         (i_rmii_mode ? rxd_o[1] : rxd_o == mrpd_pkg::CORRUPT_NIBBLE);
   endproperty
   a_err_data: assert property (p_err_data) else $error("err data");
   property p_merge;
      @(posedge ref_clk) disable iff (i_link_srst)
         i_rmii_mode && rx_dv |-> crs;
   endproperty
   a_merge: assert property (p_merge) else $error("crs merge");
   property p_col;
      @(posedge ref_clk) disable iff (i_link_srst)
         col_o |-> !i_full_duplex && !i_rmii_mode;
   endproperty
   a_col: assert property (p_col) else $error("col mode");
   property p_strap;
      @(posedge ref_clk) disable iff (i_link_srst)
         $rose(rxd_oe) |-> $rose(col_oe);
   endproperty
   a_strap: assert property (p_strap) else $error("strap release");
   //////////////////////////////
   // Controller end, core clock domain
   property p_mdc;
      @(posedge i_core_clk) disable iff (i_srst)
         $rose(mdc) |-> mdc [*3] ##1 !mdc;
   endproperty
   a_mdc: assert property (p_mdc) else $error("mdc rate");
   // Changes only while tx clock is low keep the rising edge clean
   property p_tx_edge;
      @(posedge i_core_clk) disable iff (i_srst)
         $changed(tx_en) || $changed(txd) |-> !tx_clk;
   endproperty
   a_tx_edge: assert property (p_tx_edge) else $error("tx edge");
endmodule

// [mrpd_link_if.sv]
// Pin bundle joining both ends; resolves two-way pin pulls.
// Assumes the bench drives ref_clk.
`timescale 1ns/1ns
interface mrpd_link_if
(
   input logic ref_clk
);
   logic tx_clk;
   logic tx_en;
   logic [3:0] txd;
   logic rx_clk;
   logic rx_dv;
   logic rx_er;
   logic crs;
   logic [3:0] rxd_o;
   logic rxd_oe;
   logic [3:0] rxd;
   logic col_o;
   logic col_oe;
   logic col;
   logic mdc;
   logic mdio_dev_o;
   logic mdio_dev_oe;
   logic mdio_mac_o;
   logic mdio_mac_oe;
   logic mdio;

   // Released strap pins fall back to their weak pulls
   assign rxd = rxd_oe ? rxd_o : mrpd_pkg::STRAP_PULL_UPPER;
   assign col = col_oe ? col_o : mrpd_pkg::STRAP_PULL_BIT0;
   // Pulled-up shared line: low wins
   assign mdio = (mdio_dev_oe ? mdio_dev_o : 1'b1) &
                 (mdio_mac_oe ? mdio_mac_o : 1'b1);

   modport dev (input ref_clk, output tx_clk, input tx_en, input txd,
                output rx_clk, output rx_dv, output rx_er, output crs,
                output rxd_o, output rxd_oe, input rxd, output col_o,
                output col_oe, input col, input mdc, output mdio_dev_o,
                output mdio_dev_oe, input mdio);
   modport mac (input ref_clk, input tx_clk, output tx_en, output txd,
                input rx_clk, input rx_dv, input rx_er, input crs,
                input rxd, input col, output mdc, output mdio_mac_o,
                output mdio_mac_oe, input mdio);
endinterface

// [mrpd_mac_end.sv]
// Controller end of the MII/RMII data port.
// Assumes i_core_clk at 125 MHz, link pins asynchronous to it,
// link clocks slow enough to sample.
`timescale 1ns/1ns
module mrpd_mac_end
(
   input wire logic i_core_clk,
   input wire logic i_srst,
   mrpd_link_if.mac link,
   input wire logic i_rmii_mode,
   input wire logic i_speed100,
   input wire logic i_tx_valid,
   input wire logic [7:0] i_tx_data,
   output logic o_tx_ready,
   input wire logic i_mgmt_drive,
   input wire logic i_mgmt_bit,
   output logic o_mgmt_bit,
   output logic o_rx_valid,
   output logic [7:0] o_rx_data,
   output logic o_rx_end,
   output logic o_rx_err,
   output logic o_crs,
   output logic o_col
);
   //////////////////////////////
   // Pin sampling and edge detection
   logic [11:0] s;
   logic [2:0] ck_r;
   logic [3:0] rdiv_r;
   logic [3:0] rdiv_nxt;
   logic [3:0] rlim;
   logic ref_rise;
   logic ref_fall;
   logic tx_stb;
   logic rx_stb;
   logic dv_in;

   mrpd_pin_sync #(.WIDTH(12)) u_sync
   (
      .i_clk(i_core_clk),
      .i_srst(i_srst),
      .i_pin({link.ref_clk, link.tx_clk, link.rx_clk, link.rx_dv,
              link.rx_er, link.crs, link.col, link.mdio, link.rxd}),
      .o_level(s)
   );

   // RMII times both directions on ref; MII on the device clocks
   always_comb
   begin
      rlim = i_speed100 ? mrpd_pkg::RMII_DIV_100 : mrpd_pkg::RMII_DIV_10;
      ref_rise = s[11] & ~ck_r[2];
      ref_fall = ~s[11] & ck_r[2];
      rdiv_nxt = rdiv_r;
      if (ref_rise)
         rdiv_nxt = (rdiv_r == rlim - 4'h1) ? 4'h0 : rdiv_r + 4'h1;
      if (i_rmii_mode) // R3
      begin
         tx_stb = ref_fall & (rdiv_r == 4'h0);
         rx_stb = ref_rise & (rdiv_r == rlim - 4'h1);
      end
      else
      begin
         tx_stb = ~s[10] & ck_r[1]; // R5
         rx_stb = s[9] & ~ck_r[0];
      end
      dv_in = i_rmii_mode ? s[6] : s[8];
   end

   always_ff @(posedge i_core_clk)
   begin
      ck_r <= i_srst ? 3'h0 : s[11:9];
      rdiv_r <= i_srst ? 4'h0 : rdiv_nxt;
   end

   //////////////////////////////
   // Transmit: new symbol after each falling edge, stable at rising
   logic tact_r;
   logic tact_nxt;
   logic [7:0] tbyte_r;
   logic [7:0] tbyte_nxt;
   logic [1:0] tidx_r;
   logic [1:0] tidx_nxt;
   logic ten_r;
   logic ten_nxt;
   logic [3:0] txd_r;
   logic [3:0] txd_nxt;
   logic need;
   logic [1:0] last;

   // Low nibble or lowest dibit goes first
   function automatic logic [3:0] sym(input logic [7:0] b,
                                      input logic [1:0] i,
                                      input logic rm);
      logic [7:0] sh;
      sh = b >> {i, 1'b0};
      if (rm)
         sym = {2'h0, sh[1:0]};
      else
         sym = i[0] ? b[7:4] : b[3:0];
   endfunction

   always_comb
   begin
      last = i_rmii_mode ? 2'h3 : 2'h1;
      need = ~tact_r | (tidx_r == last);
      o_tx_ready = tx_stb & need;
      tact_nxt = tact_r;
      tbyte_nxt = tbyte_r;
      tidx_nxt = tidx_r;
      ten_nxt = ten_r;
      txd_nxt = txd_r;
      if (tx_stb)
      begin
         if (need && i_tx_valid)
         begin
            tbyte_nxt = i_tx_data;
            tidx_nxt = 2'h0;
            tact_nxt = 1'b1;
            ten_nxt = 1'b1; // R4
            txd_nxt = sym(i_tx_data, 2'h0, i_rmii_mode); // R5
         end
         else if (need)
         begin
            tact_nxt = 1'b0;
            ten_nxt = 1'b0;
            txd_nxt = 4'h0;
         end
         else
         begin
            tidx_nxt = tidx_r + 2'h1;
            txd_nxt = sym(tbyte_r, tidx_r + 2'h1, i_rmii_mode);
         end
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         tact_r <= 1'b0;
         tbyte_r <= 8'h00;
         tidx_r <= 2'h0;
         ten_r <= 1'b0;
         txd_r <= 4'h0;
      end
      else
      begin
         tact_r <= tact_nxt;
         tbyte_r <= tbyte_nxt;
         tidx_r <= tidx_nxt;
         ten_r <= ten_nxt;
         txd_r <= txd_nxt;
      end
   end

   assign link.tx_en = ten_r;
   assign link.txd = txd_r;

   //////////////////////////////
   // Receive: assemble bytes, flag errors per frame
   logic [7:0] rbyte_r;
   logic [7:0] rbyte_nxt;
   logic [1:0] ridx_r;
   logic [1:0] ridx_nxt;
   logic rerr_r;
   logic rerr_nxt;
   logic rdvq_r;
   logic rdvq_nxt;
   logic rv_nxt;
   logic [7:0] rd_nxt;
   logic re_nxt;
   logic rx_err_nxt;

   always_comb
   begin
      rbyte_nxt = rbyte_r;
      ridx_nxt = ridx_r;
      rerr_nxt = rerr_r;
      rdvq_nxt = rdvq_r;
      rv_nxt = 1'b0;
      rd_nxt = o_rx_data;
      re_nxt = 1'b0;
      rx_err_nxt = o_rx_err;
      if (rx_stb)
      begin
         rdvq_nxt = dv_in;
         if (dv_in) // R7 R10
         begin
            rbyte_nxt = i_rmii_mode ? {s[1:0], rbyte_r[7:2]}
                                    : {s[3:0], rbyte_r[7:4]};
            rerr_nxt = rerr_r | s[7]; // R8
            ridx_nxt = ridx_r + 2'h1;
            if (ridx_r == last)
            begin
               rv_nxt = 1'b1;
               rd_nxt = rbyte_nxt;
               ridx_nxt = 2'h0;
            end
         end
         else
         begin
            ridx_nxt = 2'h0;
            rerr_nxt = 1'b0;
            if (rdvq_r)
            begin
               re_nxt = 1'b1;
               rx_err_nxt = rerr_r;
            end
         end
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         rbyte_r <= 8'h00;
         ridx_r <= 2'h0;
         rerr_r <= 1'b0;
         rdvq_r <= 1'b0;
         o_rx_valid <= 1'b0;
         o_rx_data <= 8'h00;
         o_rx_end <= 1'b0;
         o_rx_err <= 1'b0;
         o_crs <= 1'b0;
         o_col <= 1'b0;
         o_mgmt_bit <= 1'b1;
      end
      else
      begin
         rbyte_r <= rbyte_nxt;
         ridx_r <= ridx_nxt;
         rerr_r <= rerr_nxt;
         rdvq_r <= rdvq_nxt;
         o_rx_valid <= rv_nxt;
         o_rx_data <= rd_nxt;
         o_rx_end <= re_nxt;
         o_rx_err <= rx_err_nxt;
         o_crs <= s[6]; // R12 R13
         o_col <= s[5]; // R15
         o_mgmt_bit <= s[4];
      end
   end

   //////////////////////////////
   // Management clock divider and line drive
   logic [3:0] mcnt_r;
   logic [3:0] mcnt_nxt;
   logic mdc_r;
   logic mdc_nxt;

   always_comb
   begin
      mcnt_nxt = mcnt_r + 4'h1;
      mdc_nxt = mdc_r;
      if (mcnt_r == mrpd_pkg::MDC_HALF - 4'h1)
      begin
         mcnt_nxt = 4'h0;
         mdc_nxt = ~mdc_r; // R16
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      mcnt_r <= i_srst ? 4'h0 : mcnt_nxt;
      mdc_r <= i_srst ? 1'b0 : mdc_nxt;
   end

   assign link.mdc = mdc_r;
   assign link.mdio_mac_oe = i_mgmt_drive; // R17
   assign link.mdio_mac_o = i_mgmt_bit;
endmodule

// [mrpd_phy_end.sv]
// Transceiver end of the MII/RMII data port.
// Assumes i_link_clk is the reference clock and i_srst is synchronous
// to it; line side modelled as nibble levels.
`timescale 1ns/1ns
module mrpd_phy_end
(
   input wire logic i_link_clk,
   input wire logic i_srst,
   mrpd_link_if.dev link,
   input wire logic i_rmii_mode,
   input wire logic i_speed100,
   input wire logic i_full_duplex,
   input wire logic i_line_dv,
   input wire logic [3:0] i_line_nibble,
   input wire logic i_line_err,
   input wire logic i_line_active,
   input wire logic i_mgmt_drive,
   input wire logic i_mgmt_bit,
   output logic o_line_take,
   output logic o_line_tx_en,
   output logic [3:0] o_line_tx_nibble,
   output logic o_line_tx_strobe,
   output logic [4:0] o_phy_addr,
   output logic o_strap_done
);
   //////////////////////////////
   // Symbol timing
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;
   logic clk_r;
   logic clk_nxt;
   logic [3:0] lim;
   logic tick;
   logic rise;
   logic fall;

   // One counter times both clocks so they keep a fixed phase to ref
   always_comb
   begin
      if (i_rmii_mode)
         lim = i_speed100 ? mrpd_pkg::RMII_DIV_100 : mrpd_pkg::RMII_DIV_10;
      else
         lim = i_speed100 ? mrpd_pkg::MII_HALF_100 : mrpd_pkg::MII_HALF_10;
      tick = (cnt_r == lim - 4'h1);
      cnt_nxt = tick ? 4'h0 : cnt_r + 4'h1;
      clk_nxt = i_rmii_mode ? 1'b0 : (tick ? ~clk_r : clk_r); // R1 R3
      rise = tick & (i_rmii_mode | ~clk_r); // R3
      fall = tick & (i_rmii_mode | clk_r);
   end

   always_ff @(posedge i_link_clk)
   begin
      if (i_srst)
      begin
         cnt_r <= 4'h0;
         clk_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         clk_r <= clk_nxt; // R2
      end
   end

   // Both MII clocks come straight from the divider flop, never gated
   assign link.tx_clk = clk_r; // R1 R2
   // Receive clock assumes recovery has locked to the reference
   assign link.rx_clk = clk_r; // R6

   //////////////////////////////
   // Transmit path: pins sampled on the rising timing edge
   logic tph_r;
   logic tph_nxt;
   logic [1:0] tlow_r;
   logic [1:0] tlow_nxt;
   logic ten_r;
   logic ten_nxt;
   logic [3:0] tnib_r;
   logic [3:0] tnib_nxt;
   logic tstb_r;
   logic tstb_nxt;

   always_comb
   begin
      tph_nxt = tph_r;
      tlow_nxt = tlow_r;
      ten_nxt = ten_r;
      tnib_nxt = tnib_r;
      tstb_nxt = 1'b0;
      if (rise)
      begin
         ten_nxt = link.tx_en; // R4
         if (!link.tx_en)
            tph_nxt = 1'b0;
         else if (!i_rmii_mode)
         begin
            tnib_nxt = link.txd; // R5
            tstb_nxt = 1'b1;
         end
         else if (!tph_r)
         begin
            tlow_nxt = link.txd[1:0]; // R5
            tph_nxt = 1'b1;
         end
         else
         begin
            tnib_nxt = {link.txd[1:0], tlow_r};
            tstb_nxt = 1'b1;
            tph_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge i_link_clk)
   begin
      if (i_srst)
      begin
         tph_r <= 1'b0;
         tlow_r <= 2'h0;
         ten_r <= 1'b0;
         tnib_r <= 4'h0;
         tstb_r <= 1'b0;
      end
      else
      begin
         tph_r <= tph_nxt;
         tlow_r <= tlow_nxt;
         ten_r <= ten_nxt;
         tnib_r <= tnib_nxt;
         tstb_r <= tstb_nxt;
      end
   end

   assign o_line_tx_en = ten_r;
   assign o_line_tx_nibble = tnib_r;
   assign o_line_tx_strobe = tstb_r;

   //////////////////////////////
   // Receive path: pins change on the falling timing edge
   logic rph_r;
   logic rph_nxt;
   logic [3:0] rhold_r;
   logic [3:0] rhold_nxt;
   logic [3:0] rxd_r;
   logic [3:0] rxd_nxt;
   logic rdv_r;
   logic rdv_nxt;
   logic rer_r;
   logic rer_nxt;
   logic take;
   logic [3:0] fresh;

   always_comb
   begin
      // Bad symbols are overwritten so a controller ignoring rx_er
      // still sees a broken frame check
      fresh = i_line_err ? mrpd_pkg::CORRUPT_NIBBLE : i_line_nibble; // R9
      rph_nxt = rph_r;
      rhold_nxt = rhold_r;
      rxd_nxt = rxd_r;
      rdv_nxt = rdv_r;
      rer_nxt = rer_r;
      take = 1'b0;
      if (fall)
      begin
         if (!i_rmii_mode || !rph_r)
         begin
            take = 1'b1;
            rdv_nxt = i_line_dv; // R7
            rer_nxt = i_line_dv & i_line_err; // R8
            rhold_nxt = fresh;
            if (!i_line_dv)
               rxd_nxt = 4'h0;
            else if (i_rmii_mode)
            begin
               rxd_nxt = {2'h0, fresh[1:0]}; // R10
               rph_nxt = 1'b1;
            end
            else
               rxd_nxt = fresh; // R10
         end
         else
         begin
            rxd_nxt = {2'h0, rhold_r[3:2]}; // R10
            rph_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge i_link_clk)
   begin
      if (i_srst)
      begin
         rph_r <= 1'b0;
         rhold_r <= 4'h0;
         rxd_r <= 4'h0;
         rdv_r <= 1'b0;
         rer_r <= 1'b0;
      end
      else
      begin
         rph_r <= rph_nxt;
         rhold_r <= rhold_nxt;
         rxd_r <= rxd_nxt;
         rdv_r <= rdv_nxt;
         rer_r <= rer_nxt;
      end
   end

   assign o_line_take = take;
   assign link.rxd_o = rxd_r;
   assign link.rx_dv = rdv_r;
   assign link.rx_er = rer_r;

   //////////////////////////////
   // Carrier and collision
   logic crs_r;
   logic crs_nxt;
   logic col_r;
   logic col_nxt;

   always_comb
   begin
      if (i_rmii_mode)
         crs_nxt = i_line_active | rdv_r; // R13
      else
         crs_nxt = i_line_active; // R12
      // Only half duplex MII can report a collision
      col_nxt = ~i_rmii_mode & ~i_full_duplex & ten_r & i_line_active; // R14 R15
   end

   always_ff @(posedge i_link_clk)
   begin
      if (i_srst)
      begin
         crs_r <= 1'b0;
         col_r <= 1'b0;
      end
      else
      begin
         crs_r <= crs_nxt;
         col_r <= col_nxt;
      end
   end

   assign link.crs = crs_r;
   assign link.col_o = col_r;

   //////////////////////////////
   // Address straps read while the receive pins are released
   logic [4:0] strap_lvl;
   logic [1:0] swait_r;
   logic [1:0] swait_nxt;
   logic sdone_r;
   logic sdone_nxt;
   logic [4:0] addr_r;
   logic [4:0] addr_nxt;

   mrpd_pin_sync #(.WIDTH(5)) u_strap_sync
   (
      .i_clk(i_link_clk),
      .i_srst(i_srst),
      .i_pin({link.rxd, link.col}),
      .o_level(strap_lvl)
   );

   // Wait out the synchroniser before trusting the strap levels
   always_comb
   begin
      swait_nxt = swait_r;
      sdone_nxt = sdone_r;
      addr_nxt = addr_r;
      if (!sdone_r)
      begin
         if (swait_r == mrpd_pkg::STRAP_WAIT)
         begin
            addr_nxt = strap_lvl; // R11
            sdone_nxt = 1'b1;
         end
         else
            swait_nxt = swait_r + 2'h1;
      end
   end

   always_ff @(posedge i_link_clk)
   begin
      if (i_srst)
      begin
         swait_r <= 2'h0;
         sdone_r <= 1'b0;
         addr_r <= mrpd_pkg::ADDR_DEFAULT; // R11
      end
      else
      begin
         swait_r <= swait_nxt;
         sdone_r <= sdone_nxt;
         addr_r <= addr_nxt;
      end
   end

   // Pins stay released until the strap is taken
   assign link.rxd_oe = sdone_r; // R11
   assign link.col_oe = sdone_r;
   assign o_phy_addr = addr_r;
   assign o_strap_done = sdone_r;

   //////////////////////////////
   // Management line: driven only on request, released otherwise
   logic mdrv_r;
   logic mbit_r;

   always_ff @(posedge i_link_clk)
   begin
      if (i_srst)
      begin
         mdrv_r <= 1'b0;
         mbit_r <= 1'b1;
      end
      else
      begin
         mdrv_r <= i_mgmt_drive; // R17
         mbit_r <= i_mgmt_bit;
      end
   end

   assign link.mdio_dev_oe = mdrv_r;
   assign link.mdio_dev_o = mbit_r;
endmodule

// [mrpd_pin_sync.sv]
// Three-stage pin synchroniser with agreement filter.
// Assumes inputs asynchronous to i_clk.
`timescale 1ns/1ns
module mrpd_pin_sync
#(
   parameter int WIDTH = 1
)
(
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic [WIDTH-1:0] i_pin,
   output logic [WIDTH-1:0] o_level
);
   initial
   begin
      if (WIDTH < 1)
         $error("mrpd_pin_sync: WIDTH must be at least 1");
   end

   //////////////////////////////
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++)
      begin : g_bit
         logic s1_r;
         logic s2_r;
         logic s3_r;
         logic lvl_r;
         logic lvl_nxt;
         // First stage feeds only the second stage
         always_comb
         begin
            lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
         end
         always_ff @(posedge i_clk)
         begin
            s1_r <= i_pin[g];
            s2_r <= s1_r;
            s3_r <= s2_r;
            lvl_r <= i_srst ? 1'b0 : lvl_nxt;
         end
         assign o_level[g] = lvl_r;
      end
   endgenerate
endmodule

// [mrpd_pkg.sv]
// Constants shared by both ends of the data port.
// Assumes device end on reference clock, controller on core clock.
// What this block does
// (R1) MII transmit clock at 25 or 2.5 MHz
// (R2) Transmit clock phase locked to reference clock
// (R3) RMII times both directions on reference
// (R4) Controller marks transmit data with enable high
// (R5) Controller sends data on transmit clock rising; the controller here changes txd after the falling edge
// (R6) MII receive clock at 25 or 2.5 MHz
// (R7) Receive valid marks data, independent of carrier
// (R8) Receive error high on error symbol
// (R9) Received data corrupted on receive error
// (R10) Decoded symbols on receive bus, clock synchronous
// (R11) Address strapped from receive pins, default 0x01
// (R12) MII carrier sense high when medium busy
// (R13) RMII merges carrier with receive valid
// (R14) Collision low in full duplex MII
// (R15) Collision only when both media active
// (R16) Management clock at most 25 MHz
// (R17) Management data line released when other drives
package mrpd_pkg;
   // Reference clock cycles per half period of the MII clocks
   localparam logic [3:0] MII_HALF_100 = 4'h1;
   localparam logic [3:0] MII_HALF_10 = 4'ha;
   // Reference clock cycles per RMII symbol
   localparam logic [3:0] RMII_DIV_100 = 4'h1;
   localparam logic [3:0] RMII_DIV_10 = 4'ha;
   // Pattern forced onto the receive bus during an error
   localparam logic [3:0] CORRUPT_NIBBLE = 4'he;
   // Strap pulls and the resulting default address
   localparam logic [3:0] STRAP_PULL_UPPER = 4'h0;
   localparam logic STRAP_PULL_BIT0 = 1'b1;
   localparam logic [4:0] ADDR_DEFAULT = 5'h01;
   localparam logic [1:0] STRAP_WAIT = 2'h3;
   // Management clock limit and the core clock rate
   localparam int unsigned MDC_MAX_HZ = 25_000_000;
   localparam int unsigned CORE_HZ = 125_000_000;
   localparam int unsigned MDC_HALF_INT =
      (CORE_HZ + 2 * MDC_MAX_HZ - 1) / (2 * MDC_MAX_HZ);
   localparam logic [3:0] MDC_HALF = MDC_HALF_INT[3:0];
endpackage

// [tb.sv]
// Bench joining both ends across the link bundle.
// Assumes design and checker files compiled first.
`timescale 1ns/1ns
module tb;
   logic i_core_clk = 1'b0, ref_clk = 1'b0, i_srst = 1'b1;
   logic i_link_srst = 1'b1, rmii = 1'b0, spd = 1'b1, fdx = 1'b1;
   logic line_dv = 1'b0, line_err = 1'b0, line_act = 1'b0;
   logic [3:0] line_nib = 4'h0;
   logic pd_drive = 1'b0, mc_drive = 1'b0, tx_valid = 1'b0;
   logic [7:0] tx_data = 8'h00;
   logic line_take, ltx_en, ltx_stb, strap_done, tx_ready;
   logic mgmt_bit, rx_valid, rx_end, rx_err, crs, col;
   logic [3:0] ltx_nib;
   logic [4:0] phy_addr;
   logic [7:0] rx_data;
   logic [3:0] txq[$];
   logic [7:0] rxq[$];
   logic erq[$];
   logic col_seen = 1'b0, crs_seen = 1'b0;
   int fails = 0, checked = 0;
   //////////////////////////////
   // Clocks; link edges offset so they never meet core edges
   always #4 i_core_clk = ~i_core_clk;
   initial
   begin
      #13;
      forever #40 ref_clk = ~ref_clk;
   end
   mrpd_link_if link_bus (.ref_clk(ref_clk));
   mrpd_phy_end i_mrpd_phy_end (.i_link_clk(ref_clk), .i_srst(i_link_srst),
      .link(link_bus), .i_rmii_mode(rmii), .i_speed100(spd),
      .i_full_duplex(fdx), .i_line_dv(line_dv), .i_line_nibble(line_nib),
      .i_line_err(line_err), .i_line_active(line_act),
      .i_mgmt_drive(pd_drive), .i_mgmt_bit(1'b0), .o_line_take(line_take),
      .o_line_tx_en(ltx_en), .o_line_tx_nibble(ltx_nib),
      .o_line_tx_strobe(ltx_stb), .o_phy_addr(phy_addr),
      .o_strap_done(strap_done));
   mrpd_mac_end i_mrpd_mac_end (.i_core_clk(i_core_clk), .i_srst(i_srst),
      .link(link_bus), .i_rmii_mode(rmii), .i_speed100(spd),
      .i_tx_valid(tx_valid), .i_tx_data(tx_data), .o_tx_ready(tx_ready),
      .i_mgmt_drive(mc_drive), .i_mgmt_bit(1'b0), .o_mgmt_bit(mgmt_bit),
      .o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_rx_end(rx_end),
      .o_rx_err(rx_err), .o_crs(crs), .o_col(col));
   mrpd_link_asserts i_mrpd_link_asserts (.i_core_clk(i_core_clk),
      .i_srst(i_srst), .ref_clk(ref_clk), .i_link_srst(i_link_srst),
      .i_rmii_mode(rmii), .i_speed100(spd), .i_full_duplex(fdx),
      .tx_clk(link_bus.tx_clk), .rx_clk(link_bus.rx_clk),
      .tx_en(link_bus.tx_en), .txd(link_bus.txd), .rx_dv(link_bus.rx_dv),
      .rx_er(link_bus.rx_er), .crs(link_bus.crs), .rxd_o(link_bus.rxd_o),
      .rxd_oe(link_bus.rxd_oe), .col_o(link_bus.col_o),
      .col_oe(link_bus.col_oe), .mdc(link_bus.mdc));
   //////////////////////////////
   // Monitors on both user sides; a nibble counts only with enable
   always @(posedge ref_clk)
      if (ltx_stb === 1'b1 && ltx_en === 1'b1) txq.push_back(ltx_nib);
   always @(posedge i_core_clk)
   begin
      if (rx_valid === 1'b1) rxq.push_back(rx_data);
      if (rx_end === 1'b1) erq.push_back(rx_err);
      if (col === 1'b1) col_seen = 1'b1;
      if (crs === 1'b1) crs_seen = 1'b1;
   end
   //////////////////////////////
   // Compare, verdict and access tasks
   task automatic cmp_byte(input string n, input logic [7:0] e,
                           input logic [7:0] g);
      checked++;
      if (g !== e)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cmp_bit(input string n, input logic e, input logic g);
      cmp_byte(n, {7'h0, e}, {7'h0, g});
   endtask
   task automatic print_verdict();
      if (fails == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Line nibble held until the device samples it
   task automatic rx_nib(input logic [3:0] n, input logic e, input logic v);
      int k;
      line_dv <= v;
      line_act <= v;
      line_nib <= n;
      line_err <= e;
      k = 0;
      @(posedge ref_clk);
      while (line_take !== 1'b1 && k++ < 100) @(posedge ref_clk);
   endtask
   // One byte frame; two idle nibbles let the end be seen
   task automatic rx_frame(input logic [7:0] b, input logic e);
      @(posedge ref_clk);
      rx_nib(b[3:0], 1'b0, 1'b1);
      rx_nib(b[7:4], e, 1'b1);
      rx_nib(4'h0, 1'b0, 1'b0);
      rx_nib(4'h0, 1'b0, 1'b0);
   endtask
   // Byte offered until the controller takes it
   task automatic tx_one(input logic [7:0] d);
      int k;
      tx_valid <= 1'b1;
      tx_data <= d;
      k = 0;
      @(posedge i_core_clk);
      while (tx_ready !== 1'b1 && k++ < 4000) @(posedge i_core_clk);
   endtask
   task automatic mdio_step(input logic d, input logic m, input logic e);
      int k;
      @(posedge ref_clk);
      pd_drive <= d;
      @(posedge i_core_clk);
      mc_drive <= m;
      k = 0;
      while (mgmt_bit !== e && k++ < 60) @(posedge i_core_clk);
      cmp_bit("mdio", e, mgmt_bit);
   endtask
   // Reset into a mode, then traffic both ways
   task automatic run_mode(input logic r, input logic s, input logic f);
      int k;
      @(posedge i_core_clk);
      i_srst <= 1'b1;
      @(posedge ref_clk);
      i_link_srst <= 1'b1;
      rmii <= r;
      spd <= s;
      fdx <= f;
      repeat (4) @(posedge ref_clk);
      i_link_srst <= 1'b0;
      @(posedge i_core_clk);
      i_srst <= 1'b0;
      k = 0;
      while (strap_done !== 1'b1 && k++ < 50) @(posedge ref_clk);
      cmp_byte("addr", 8'h01, {3'h0, phy_addr});
      txq.delete();
      rxq.delete();
      erq.delete();
      col_seen = 1'b0;
      crs_seen = 1'b0;
      line_act <= ~r;
      @(posedge i_core_clk);
      tx_one(8'h5a);
      tx_one(8'hc3);
      tx_valid <= 1'b0;
      k = 0;
      while (txq.size() < 4 && k++ < 4000) @(posedge i_core_clk);
      @(posedge ref_clk);
      line_act <= 1'b0;
      cmp_byte("tx0", 8'h5a, {txq[1], txq[0]});
      cmp_byte("tx1", 8'hc3, {txq[3], txq[2]});
      cmp_bit("col", ~(r | f), col_seen);
      cmp_bit("crs", ~r, crs_seen);
      rx_frame(8'h96, 1'b0);
      rx_frame(8'h3b, 1'b1);
      k = 0;
      while (erq.size() < 2 && k++ < 4000) @(posedge i_core_clk);
      cmp_byte("rx0", 8'h96, rxq[0]);
      cmp_byte("rx1", 8'heb, rxq[1]);
      cmp_bit("err0", 1'b0, erq[0]);
      cmp_bit("err1", 1'b1, erq[1]);
      cmp_bit("crs_rx", 1'b1, crs_seen);
   endtask
   //////////////////////////////
   // Main sequence and watchdog
   initial
   begin
      repeat (4) @(posedge i_core_clk);
      i_srst <= 1'b0;
      run_mode(1'b0, 1'b1, 1'b1);
      run_mode(1'b0, 1'b1, 1'b0);
      run_mode(1'b0, 1'b0, 1'b0);
      run_mode(1'b1, 1'b1, 1'b1);
      mdio_step(1'b1, 1'b0, 1'b0);
      mdio_step(1'b0, 1'b0, 1'b1);
      mdio_step(1'b0, 1'b1, 1'b0);
      mdio_step(1'b0, 1'b0, 1'b1);
      print_verdict();
   end
   initial
   begin
      #400000;
      fails++;
      print_verdict();
   end
endmodule
